/* File: src/rcft_reset_cause.sv */
// reset cause register with cpu and debug flash access
`timescale 1ns/1ps
// How it works
// RQ1: flash altered by debug port or cpu
// RQ2: writes only clear bits to zero
// RQ3: erase sets page bytes to all ones
// RQ4: write and erase timed by hardware
// RQ5: no polling, done when execution resumes
// RQ6: cpu stalled for whole flash operation
// RQ7: flash fault reset sets flash fault flag
// RQ8: pin reset sets pin reset flag
// RQ9: writing soft reset bit resets, reads one
// RQ10: clock loss bit arms detector, flags timeout
// RQ11: each reset sets only its own flag
module rcft_reset_cause #(
  parameter int write_count = rcft_pkg::write_cycles,
  parameter int erase_count = rcft_pkg::erase_cycles
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic sfr_write, // special register write strobe
  input wire logic sfr_read, // special register read strobe
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  input wire rcft_pkg::rcft_sources_type sources, // other reset requests
  input wire rcft_pkg::rcft_flash_req_type cpu_flash, // data move to flash
  input wire rcft_pkg::rcft_flash_req_type debug_flash, // two-wire port
  input wire logic [12:0] flash_read_addr,
  output logic [7:0] flash_read_data,
  output logic cpu_stall,
  output logic soft_reset_request, // one-pulse system reset from software
  output logic clock_loss_enable,
  output logic supply_reset_enable,
  output logic comparator_reset_enable
);
  // whole register state
  typedef struct packed {
    logic [7:0] cause; // read-only flags live here
    logic clock_loss_arm;
    logic supply_arm;
    logic comparator_arm;
    logic soft_pending; // soft reset under way
    logic [7:0] rdata;
    logic soft_pulse;
  } rcft_state_type;

  rcft_state_type cur, next_cur;
  rcft_pkg::rcft_flash_req_type flash_req;
  logic flash_busy;
  logic hit_w, hit_r;
  logic reset_any;

  // cause value after a power-on style reset: unused bit and power flag
  localparam logic [7:0] power_on_image =
    (8'h01 << rcft_pkg::bit_unused) | (8'h01 << rcft_pkg::bit_power_on);

  // cause value for a reset taken from a single source
  function automatic logic [7:0] cause_image(input int flag);
    cause_image = 8'h00;
    cause_image[rcft_pkg::bit_unused] = 1'b1; // unused bit reads one
    cause_image[flag] = 1'b1;
  endfunction : cause_image

  // address decode shared by the read and the write strobe
  function automatic logic reg_hit(input logic strobe,
                                   input logic [7:0] a);
    reg_hit = strobe && a == rcft_pkg::reset_cause_addr;
  endfunction : reg_hit

  // either master may start flash work; debug port wins a tie
  always_comb begin
    flash_req = debug_flash.valid ? debug_flash : cpu_flash; // RQ1
  end

  rcft_flash_timer #(
    .write_count(write_count),
    .erase_count(erase_count)
  ) u_timer (
    .clk(clk),
    .sys_rst(sys_rst),
    .req(flash_req),
    .read_addr(flash_read_addr),
    .read_data(flash_read_data),
    .busy(flash_busy)
  );

  // any other address reads zero and ignores writes
  assign hit_w = reg_hit(sfr_write, sfr_addr);
  assign hit_r = reg_hit(sfr_read, sfr_addr);
  // a source or a pending software reset means the system goes down
  assign reset_any = (|sources) || cur.soft_pending;

  // cause capture and register writes
  always_comb begin
    next_cur = cur;
    next_cur.soft_pulse = 1'b0;
    if (reset_any) begin
      // one flag for the winner, everything else cleared; power-on
      // outranks all because it leaves the rest undefined anyway
      next_cur.cause = 8'h00; // RQ11
      next_cur.cause[rcft_pkg::bit_unused] = 1'b1;
      next_cur.soft_pending = 1'b0;
      if (sources.power_on) begin
        next_cur.cause[rcft_pkg::bit_power_on] = 1'b1;
      end else if (sources.pin_reset) begin
        next_cur.cause[rcft_pkg::bit_pin_reset] = 1'b1; // RQ8
      end else if (sources.flash_fault) begin
        next_cur.cause[rcft_pkg::bit_flash_fault] = 1'b1; // RQ7
      end else if (sources.clock_loss) begin
        next_cur.cause[rcft_pkg::bit_clock_loss] = 1'b1; // RQ10
      end else if (sources.comparator) begin
        next_cur.cause[rcft_pkg::bit_comparator] = 1'b1;
      end else if (sources.watchdog) begin
        next_cur.cause[rcft_pkg::bit_watchdog] = 1'b1;
      end else begin
        next_cur.cause[rcft_pkg::bit_soft_reset] = 1'b1; // RQ9
      end
      // every reset disarms the optional sources, except that power-on leaves the supply source armed
      next_cur.clock_loss_arm = 1'b0;
      next_cur.comparator_arm = 1'b0;
      next_cur.supply_arm = sources.power_on;
    end else if (hit_w) begin
      // write side: arm bits, flags unchanged
      next_cur.clock_loss_arm = sfr_wdata[rcft_pkg::bit_clock_loss]; // RQ10
      next_cur.supply_arm = sfr_wdata[rcft_pkg::bit_power_on];
      next_cur.comparator_arm = sfr_wdata[rcft_pkg::bit_comparator];
      if (sfr_wdata[rcft_pkg::bit_soft_reset]) begin
        next_cur.soft_pending = 1'b1; // RQ9
        next_cur.soft_pulse = 1'b1;
      end
    end
    next_cur.rdata = hit_r ? cur.cause : 8'h00;
  end

  // register the state record
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      // plain reset counts as power-on
      cur <= '{power_on_image, 1'b0, 1'b1, 1'b0, 1'b0, 8'h00, 1'b0};
    end else begin
      cur <= next_cur;
    end
  end

  // outputs from flip-flops
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cpu_stall <= 1'b0;
    end else begin
      // stall from the cycle after the request until one cycle past completion
      cpu_stall <= flash_busy || flash_req.valid; // RQ6
    end
  end

  assign sfr_rdata = cur.rdata;
  assign soft_reset_request = cur.soft_pulse;
  assign clock_loss_enable = cur.clock_loss_arm;
  assign supply_reset_enable = cur.supply_arm;
  assign comparator_reset_enable = cur.comparator_arm;

  // soft reset runs in two steps: pulse first, then the captured flag
  sequence soft_pulse_seen;
    soft_reset_request;
  endsequence

  sequence soft_flag_seen;
    cur.cause == cause_image(rcft_pkg::bit_soft_reset);
  endsequence

  // a lone source request leaves exactly its own flag behind
  chk_pin_flag: assert property (@(posedge clk) disable iff (sys_rst)
    sources == 6'b000001 |=>
    cur.cause == cause_image(rcft_pkg::bit_pin_reset))
    else $error("pin reset flag wrong"); // RQ8
  chk_flash_flag: assert property (@(posedge clk) disable iff (sys_rst)
    sources == 6'b100000 |=>
    cur.cause == cause_image(rcft_pkg::bit_flash_fault))
    else $error("flash fault flag wrong"); // RQ7
  chk_clock_flag: assert property (@(posedge clk) disable iff (sys_rst)
    sources == 6'b000100 |=>
    cur.cause == cause_image(rcft_pkg::bit_clock_loss))
    else $error("clock loss flag wrong"); // RQ10
  chk_power_flag: assert property (@(posedge clk) disable iff (sys_rst)
    sources.power_on |=> cur.cause == power_on_image && supply_reset_enable)
    else $error("power on flag wrong"); // RQ11
  chk_soft_reset: assert property (@(posedge clk) disable iff (sys_rst)
    hit_w && !reset_any && sfr_wdata[rcft_pkg::bit_soft_reset] |=>
    soft_pulse_seen ##1 soft_flag_seen)
    else $error("soft reset not recorded"); // RQ9
  // the software request is one pulse, never a level
  chk_pulse_single: assert property (@(posedge clk) disable iff (sys_rst)
    soft_reset_request |=> !soft_reset_request)
    else $error("soft reset pulse too long"); // RQ9
  chk_clock_arm: assert property (@(posedge clk) disable iff (sys_rst)
    hit_w && !reset_any |=>
    clock_loss_enable == $past(sfr_wdata[rcft_pkg::bit_clock_loss]))
    else $error("clock loss arm wrong"); // RQ10
  // a reset other than power-on leaves every optional source disarmed
  chk_arms_cleared: assert property (@(posedge clk) disable iff (sys_rst)
    reset_any && !sources.power_on |=>
    !clock_loss_enable && !comparator_reset_enable && !supply_reset_enable)
    else $error("reset left a source armed"); // RQ10
  // a read returns the flags as they stood when it was taken
  chk_read_cause: assert property (@(posedge clk) disable iff (sys_rst)
    hit_r |=> sfr_rdata == $past(cur.cause))
    else $error("read data wrong"); // RQ11
  // stall must start at the edge after any accepted request
  chk_stall_start: assert property (@(posedge clk) disable iff (sys_rst)
    flash_req.valid |=> cpu_stall)
    else $error("stall missing at start"); // RQ6
  chk_one_flag: assert property (@(posedge clk) disable iff (sys_rst)
    reset_any |=> $onehot(cur.cause[6:0]))
    else $error("more than one cause"); // RQ11
  chk_stall_held: assert property (@(posedge clk) disable iff (sys_rst)
    flash_busy |=> cpu_stall)
    else $error("execution not stalled"); // RQ6
endmodule : rcft_reset_cause

/* File: src/rcft_pkg.sv */
// package for the reset cause register and flash timing block
package rcft_pkg;
  localparam logic [7:0] reset_cause_addr = 8'hEF; // special register slot
  localparam int bit_unused = 7; // reads one
  localparam int bit_flash_fault = 6;
  localparam int bit_comparator = 5;
  localparam int bit_soft_reset = 4;
  localparam int bit_watchdog = 3;
  localparam int bit_clock_loss = 2;
  localparam int bit_power_on = 1;
  localparam int bit_pin_reset = 0;
  localparam logic [7:0] flash_erased = 8'hFF; // byte value after erase
  localparam int flash_addr_w = 13; // 8 kB array
  localparam int flash_page_w = 9; // 512-byte pages
  localparam int clk_period_ns = 5; // 200 MHz system clock
  localparam int write_time_ns = 40000; // byte write time
  localparam int erase_time_ns = 20000000; // page erase time
  localparam int write_cycles = (write_time_ns + clk_period_ns - 1)
                                / clk_period_ns;
  localparam int erase_cycles = (erase_time_ns + clk_period_ns - 1)
                                / clk_period_ns;
  localparam int timer_w = 24; // wide enough for the erase count
  localparam logic [23:0] timer_zero = 24'h000000;
  localparam logic [23:0] timer_one = 24'h000001;

  // flash operation request from cpu or debug port
  typedef struct packed {
    logic valid;
    logic erase; // page erase instead of byte write
    logic [12:0] addr;
    logic [7:0] data;
  } rcft_flash_req_type;

  // reset source requests, one per source
  typedef struct packed {
    logic flash_fault;
    logic comparator;
    logic watchdog;
    logic clock_loss;
    logic power_on;
    logic pin_reset;
  } rcft_sources_type;

  typedef enum logic [1:0] {
    rcft_idle, rcft_write, rcft_erase
  } rcft_flash_state_type;
endpackage : rcft_pkg

/* File: src/rcft_flash_timer.sv */
// hardware timer and array update for flash write and erase
`timescale 1ns/1ps
module rcft_flash_timer #(
  parameter int write_count = rcft_pkg::write_cycles,
  parameter int erase_count = rcft_pkg::erase_cycles
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire rcft_pkg::rcft_flash_req_type req,
  input wire logic [12:0] read_addr,
  output logic [7:0] read_data,
  output logic busy
);
  // all state of the timer in one record
  typedef struct packed {
    rcft_pkg::rcft_flash_state_type state;
    logic [23:0] count;
    logic [12:0] addr;
    logic [7:0] data;
    logic busy;
  } rcft_timer_type;

  rcft_timer_type cur, next_cur;
  logic [7:0] mem [0:8191]; // flash array in flip-flops
  logic commit; // last cycle of an operation

  // sequencing of one operation
  always_comb begin
    next_cur = cur;
    commit = 1'b0;
    unique case (cur.state)
      rcft_pkg::rcft_idle: begin
        if (req.valid) begin
          next_cur.addr = req.addr;
          next_cur.data = req.data;
          next_cur.busy = 1'b1; // RQ6
          // duration chosen here, never by software
          if (req.erase) begin
            next_cur.state = rcft_pkg::rcft_erase;
            next_cur.count = 24'(erase_count); // RQ4
          end else begin
            next_cur.state = rcft_pkg::rcft_write;
            next_cur.count = 24'(write_count); // RQ4
          end
        end
      end
      rcft_pkg::rcft_write, rcft_pkg::rcft_erase: begin
        next_cur.count = cur.count - rcft_pkg::timer_one;
        if (cur.count == rcft_pkg::timer_one) begin
          commit = 1'b1;
          next_cur.state = rcft_pkg::rcft_idle;
          next_cur.busy = 1'b0; // RQ5
        end
      end
    endcase
  end

  // state register
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cur <= '{rcft_pkg::rcft_idle, rcft_pkg::timer_zero, 13'h0000,
               8'h00, 1'b0};
    end else begin
      cur <= next_cur;
    end
  end

  // array update; storage has no reset, like real flash
  always_ff @(posedge clk) begin
    if (commit && cur.state == rcft_pkg::rcft_write) begin
      mem[cur.addr] <= mem[cur.addr] & cur.data; // RQ2
    end
    for (int i = 0; i < 8192; i++) begin
      if (commit && cur.state == rcft_pkg::rcft_erase &&
          i[12:9] == cur.addr[12:9]) begin
        mem[i] <= rcft_pkg::flash_erased; // RQ3
      end
    end
    read_data <= mem[read_addr];
  end

  assign busy = cur.busy;

  chk_write_only_clears: assert property (@(posedge clk) disable iff (sys_rst)
    commit && cur.state == rcft_pkg::rcft_write |=>
    (mem[$past(cur.addr)] & ~$past(mem[cur.addr])) == 8'h00)
    else $error("flash write set a bit"); // RQ2
  chk_busy_on_start: assert property (@(posedge clk) disable iff (sys_rst)
    cur.state == rcft_pkg::rcft_idle && req.valid |=> busy)
    else $error("no stall at start"); // RQ6
  chk_busy_drops: assert property (@(posedge clk) disable iff (sys_rst)
    commit |=> !busy && cur.state == rcft_pkg::rcft_idle)
    else $error("stall did not end"); // RQ5
endmodule : rcft_flash_timer

/* File: sim/rcft_reset_cause_tb.sv */
// self-checking bench for the reset cause register and flash timer
`timescale 1ns/1ps
`define check(what, exp, got) begin checked++; \
  if ((got) !== (exp)) begin bad_count++; \
  $display("mismatch %s expected %h seen %h", what, exp, got); end end
module rcft_reset_cause_tb;
  logic clk; // 200 MHz system clock
  logic sys_rst; // sync reset, high
  logic sfr_write;
  logic sfr_read;
  logic [7:0] sfr_addr;
  logic [7:0] sfr_wdata;
  logic [7:0] sfr_rdata;
  rcft_pkg::rcft_sources_type sources; // per-source reset requests
  rcft_pkg::rcft_flash_req_type cpu_flash;
  rcft_pkg::rcft_flash_req_type debug_flash;
  logic [12:0] flash_read_addr;
  logic [7:0] flash_read_data;
  logic cpu_stall;
  logic soft_reset_request;
  logic clock_loss_enable;
  logic supply_reset_enable;
  logic comparator_reset_enable;
  int bad_count = 0; // mismatches seen
  int checked = 0; // comparisons made
  logic [7:0] rd; // scratch read value

  // short flash counts keep the run brief
  rcft_reset_cause #(.write_count(4), .erase_count(8)) rcft_reset_cause_i (
    .clk(clk), .sys_rst(sys_rst), .sfr_write(sfr_write),
    .sfr_read(sfr_read), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata),
    .sfr_rdata(sfr_rdata), .sources(sources), .cpu_flash(cpu_flash),
    .debug_flash(debug_flash), .flash_read_addr(flash_read_addr),
    .flash_read_data(flash_read_data), .cpu_stall(cpu_stall),
    .soft_reset_request(soft_reset_request),
    .clock_loss_enable(clock_loss_enable),
    .supply_reset_enable(supply_reset_enable),
    .comparator_reset_enable(comparator_reset_enable));

  // free running clock
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // prints counts and the verdict, then stops
  task automatic complete_run;
    $display("checked %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : complete_run

  // one-cycle register write strobe
  task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    sfr_write = 1'b1; sfr_addr = a; sfr_wdata = d;
    @(negedge clk);
    sfr_write = 1'b0;
  endtask : reg_write

  // read strobe; data is registered, valid one cycle later
  task automatic reg_read(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk);
    sfr_read = 1'b1; sfr_addr = a;
    @(negedge clk);
    sfr_read = 1'b0;
    d = sfr_rdata;
  endtask : reg_read

  // one-cycle request from a single reset source
  task automatic pulse_source(input logic [5:0] s);
    @(negedge clk);
    sources = s;
    @(negedge clk);
    sources = '0;
  endtask : pulse_source

  // flash request; stall must cover the hardware timed span
  task automatic flash_op(input logic dbg, input logic er,
                          input logic [12:0] a, input logic [7:0] d);
    rcft_pkg::rcft_flash_req_type r;
    int n;
    int span;
    r = {1'b1, er, a, d};
    span = er ? 8 : 4;
    n = 0;
    @(negedge clk);
    if (dbg) debug_flash = r; else cpu_flash = r;
    @(negedge clk);
    debug_flash = '0; cpu_flash = '0;
    `check("stall_start", 1'b1, cpu_stall)
    while (cpu_stall === 1'b1 && n < 100) begin
      @(negedge clk);
      n++;
    end
    `check("stall_span", 1'b1, n >= span && n <= span + 4)
  endtask : flash_op

  // array read with one cycle latency
  task automatic flash_read(input logic [12:0] a, output logic [7:0] d);
    @(negedge clk);
    flash_read_addr = a;
    @(negedge clk);
    d = flash_read_data;
  endtask : flash_read

  // values left by the power-on reset
  task automatic test_reset;
    reg_read(8'hEF, rd);
    `check("cause_after_power", 8'h82, rd)
    `check("supply_arm", 1'b1, supply_reset_enable)
    reg_read(8'h00, rd);
    `check("unmapped_read", 8'h00, rd)
    $display("test reset done");
  endtask : test_reset

  // every source sets only its own flag
  task automatic test_causes;
    logic [7:0] exp [6] = '{8'h81, 8'h82, 8'h84, 8'h88, 8'hA0, 8'hC0};
    for (int i = 0; i < 6; i++) begin
      pulse_source(6'h01 << i);
      reg_read(8'hEF, rd);
      `check("cause_flag", exp[i], rd)
    end
    $display("test causes done");
  endtask : test_causes

  // arm bits follow writes; flags stay as captured
  task automatic test_arms;
    reg_write(8'hEF, 8'h26);
    `check("clock_loss_arm", 1'b1, clock_loss_enable)
    `check("comparator_arm", 1'b1, comparator_reset_enable)
    `check("supply_arm_set", 1'b1, supply_reset_enable)
    reg_read(8'hEF, rd);
    `check("cause_kept", 8'hC0, rd)
    reg_write(8'hEF, 8'h02);
    `check("clock_loss_disarm", 1'b0, clock_loss_enable)
    $display("test arms done");
  endtask : test_arms

  // software reset pulse and its flag
  task automatic test_soft;
    reg_write(8'hEF, 8'h16);
    `check("soft_pulse", 1'b1, soft_reset_request)
    @(negedge clk);
    `check("soft_pulse_end", 1'b0, soft_reset_request)
    reg_read(8'hEF, rd);
    `check("soft_cause", 8'h90, rd)
    `check("arm_cleared", 1'b0, clock_loss_enable)
    $display("test soft done");
  endtask : test_soft

  // erase, clearing writes and a debug port write
  task automatic test_flash;
    flash_op(1'b0, 1'b1, 13'h0205, 8'h00);
    flash_read(13'h0205, rd);
    `check("erased_byte", rcft_pkg::flash_erased, rd)
    flash_read(13'h03FF, rd);
    `check("erased_page_end", 8'hFF, rd)
    flash_op(1'b0, 1'b0, 13'h0205, 8'h5A);
    flash_read(13'h0205, rd);
    `check("cpu_write", 8'h5A, rd)
    flash_op(1'b0, 1'b0, 13'h0205, 8'hF0);
    flash_read(13'h0205, rd);
    `check("write_clears_only", 8'h50, rd)
    flash_op(1'b1, 1'b0, 13'h0206, 8'h3C);
    flash_read(13'h0206, rd);
    `check("debug_write", 8'h3C, rd)
    $display("test flash done");
  endtask : test_flash

  // a hang counts as a mismatch
  initial begin
    #20000;
    bad_count++;
    $display("watchdog expired");
    complete_run;
  end

  // main sequence
  initial begin
    sys_rst = 1'b1; sfr_write = 1'b0; sfr_read = 1'b0;
    sfr_addr = 8'h00; sfr_wdata = 8'h00; sources = '0;
    cpu_flash = '0; debug_flash = '0; flash_read_addr = 13'h0000;
    repeat (2) @(posedge clk);
    @(negedge clk);
    sys_rst = 1'b0;
    test_reset;
    test_causes;
    test_arms;
    test_soft;
    test_flash;
    complete_run;
  end
endmodule : rcft_reset_cause_tb
